// *** logic/ccs_defines.svh ***
// Constants of the clock synthesis unit: ratios, limits, timing and reset values
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

`define CCS_PLL_MULT        8
`define CCS_OSC_FREQ_MHZ    8
`define CCS_MAX_SYS_MHZ     32
`define CCS_CLK_PERIOD_NS   5
`define CCS_LOR_TIME_NS     500
`define CCS_LOR_CYCLES      ((`CCS_LOR_TIME_NS + `CCS_CLK_PERIOD_NS - 1) / `CCS_CLK_PERIOD_NS)
`define CCS_PSCL_MAX_CODE   3'h5
`define CCS_ADC_SHIFT       3
`define CCS_RST_REF_SEL     1'b0

`endif

// *** logic/ccs_div_if.sv ***
// Carrier between the clock unit and its power-of-two dividers
`timescale 1ns/1ps
interface ccs_div_if;
   logic       src;
   logic [2:0] shift;
   logic       out;

   modport master  (output src, output shift, input  out);
   modport divider (input  src, input  shift, output out);
endinterface // ccs_div_if

// *** logic/ccs_divider.sv ***
// Power-of-two divider of a sampled clock level
`timescale 1ns/1ps
module ccs_divider #(
   parameter int W = 5
) (
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   ccs_div_if.divider d
);
   import ccs_pkg::*;

   logic         src_d_r;
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic         out_r;

   // ----------------------------------------
   // Elaboration check
   // ----------------------------------------
   if (W < 5) begin : g_bad_w
      $error("Divider too narrow for divide by 32");
   end

   always_comb begin
      cnt_nxt = cnt_r;
      if (d.src && !src_d_r) begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         src_d_r <= 1'b0;
         cnt_r   <= '0;
      end else begin
         src_d_r <= d.src;
         cnt_r   <= cnt_nxt;
      end
   end

   // Shift 0 passes the level through, one cycle late like the others
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_r <= 1'b0;
      end else if (d.shift == 3'h0) begin
         out_r <= d.src;
      end else begin
         out_r <= cnt_nxt[d.shift - 3'h1];
      end
   end

   assign d.out = out_r;
endmodule // ccs_divider

// *** logic/ccs_pkg.sv ***
// Types and helpers shared by the clock synthesis modules
package ccs_pkg;
`include "ccs_defines.svh"

   typedef logic [2:0] ccs_pscl_t;

   typedef enum logic [0:0] {
      CCS_SRC_OSC = 1'b0,
      CCS_SRC_PLL = 1'b1
   } ccs_src_e;

   typedef enum logic [0:0] {
      CCS_ST_RUN  = 1'b0,
      CCS_ST_SHUT = 1'b1
   } ccs_state_e;

   // Codes above the last ratio saturate at divide by 32
   function automatic ccs_pscl_t ccs_pscl_shift(input ccs_pscl_t code);
      return (code > `CCS_PSCL_MAX_CODE) ? `CCS_PSCL_MAX_CODE : code;
   endfunction

endpackage

// *** logic/ccs_top.sv ***
// On-chip clock synthesis unit: reference select, PLL postscaler, clock outputs, safety shutdown
//
// How it works
// - Reference from internal oscillator or external input
// - Without PLL, 2X equals the reference
// - With PLL, 2X is reference times eight over postscaler
// - 3-bit postscaler: divide 1, 2, 4, 8, 16, 32
// - 3X clock goes to PWM and timer
// - System clock is 2X halved, 50% duty
// - Lost reference while 2X runs from the PLL triggers safety shutdown
// - Oscillator can power down or stand by
// - PLL powers down independently
// - Oscillator-based system clock tops at 32MHz
// - Selected reference, ADC and high-speed peripheral clocks out
// - Internal reference after reset; external on request
// - Oscillator is the 8MHz PLL reference
// - Interrupt on PLL lock and reference loss
`timescale 1ns/1ps
`include "ccs_defines.svh"
module ccs_top #(
   parameter int ADC_SHIFT = `CCS_ADC_SHIFT
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_i,
   input  wire logic              osc_clk_i,
   input  wire logic              external_clock_input_i,
   input  wire logic              pll_clk_i,
   input  wire logic              pll_3x_clk_i,
   input  wire logic              pll_lock_i,
   input  wire logic              external_reference_select_i,
   input  wire logic              pll_select_i,
   input  wire ccs_pkg::ccs_pscl_t postscaler_i,
   input  wire logic              osc_power_down_i,
   input  wire logic              osc_standby_i,
   input  wire logic              pll_power_down_i,
   input  wire logic              shutdown_enable_i,
   input  wire logic              lock_irq_en_i,
   input  wire logic              lor_irq_en_i,
   input  wire logic              lock_flag_clr_i,
   input  wire logic              lor_flag_clr_i,
   output logic                   osc_pwr_dn_o,
   output logic                   osc_stby_o,
   output logic                   pll_pwr_dn_o,
   output logic                   clk_2x_o,
   output logic                   clk_3x_o,
   output logic                   sys_clk_o,
   output logic                   osc_clk_o,
   output logic                   adc_clk_o,
   output logic                   hsp_clk_o,
   output logic                   pll_src_active_o,
   output logic                   ext_ref_active_o,
   output logic                   lock_flag_o,
   output logic                   lor_flag_o,
   output logic                   shutdown_o,
   output logic                   irq_o
);
   import ccs_pkg::*;

   localparam int       LOR_CYC = `CCS_LOR_CYCLES;
   localparam int       SYS_MHZ = `CCS_OSC_FREQ_MHZ * `CCS_PLL_MULT / 2;
   localparam logic [7:0] LOR_MAX = LOR_CYC[7:0];

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (LOR_CYC > 255) begin : g_bad_lor
      $error("Loss-of-reference count too wide");
   end
   if (SYS_MHZ > `CCS_MAX_SYS_MHZ) begin : g_bad_fmax
      $error("System clock above ceiling");
   end
   if (ADC_SHIFT < 0 || ADC_SHIFT > 5) begin : g_bad_adc
      $error("ADC shift out of range");
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Bits: 0 osc, 1 external, 2 pll, 3 pll 3x, 4 lock
   logic [4:0] s1_r, s2_r, s3_r, cln_r;
   logic [4:0] pin_vec;
   assign pin_vec = {pll_lock_i, pll_3x_clk_i, pll_clk_i, external_clock_input_i, osc_clk_i};

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_r  <= 5'h00;
         s2_r  <= 5'h00;
         s3_r  <= 5'h00;
         cln_r <= 5'h00;
      end else begin
         s1_r  <= pin_vec;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         // Only accept a change once two stages agree
         cln_r <= (s2_r & ~(s2_r ^ s3_r)) | (cln_r & (s2_r ^ s3_r));
      end
   end

   // ----------------------------------------
   // Power controls
   // ----------------------------------------
   ccs_state_e st_r;
   logic       osc_pwr_dn_r, osc_stby_r, pll_pwr_dn_r;

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         osc_pwr_dn_r <= 1'b0;
         osc_stby_r   <= 1'b0;
         pll_pwr_dn_r <= 1'b0;
      end else begin
         osc_pwr_dn_r <= osc_power_down_i;
         osc_stby_r   <= osc_standby_i & ~osc_power_down_i;
         pll_pwr_dn_r <= pll_power_down_i | (st_r == CCS_ST_SHUT);
      end
   end

   // ----------------------------------------
   // Reference selection
   // ----------------------------------------
   logic ref_sel_r, ref_lvl_r, ref_lvl_d_r, ref_new;
   assign ref_new = external_reference_select_i ? cln_r[1] : cln_r[0];

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_sel_r <= `CCS_RST_REF_SEL;
      end else if (external_reference_select_i != ref_sel_r && !ref_lvl_r && !ref_new) begin
         ref_sel_r <= external_reference_select_i;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_lvl_r   <= 1'b0;
         ref_lvl_d_r <= 1'b0;
      end else begin
         ref_lvl_r   <= ref_sel_r ? cln_r[1] : cln_r[0];
         ref_lvl_d_r <= ref_lvl_r;
      end
   end

   // ----------------------------------------
   // Loss of reference and shutdown
   // ----------------------------------------
   // Dormant oscillator is not a loss: it was stopped on purpose
   logic       mon, lor_now;
   logic [7:0] lor_cnt_r;
   assign mon     = ref_sel_r || !(osc_pwr_dn_r || osc_stby_r);
   assign lor_now = (lor_cnt_r == LOR_MAX);

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lor_cnt_r <= 8'h00;
      end else if (!mon || (ref_lvl_r ^ ref_lvl_d_r)) begin
         lor_cnt_r <= 8'h00;
      end else if (!lor_now) begin
         lor_cnt_r <= lor_cnt_r + 8'h01;
      end
   end

   ccs_src_e path_r;

   // Shutdown only releases by reset
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= CCS_ST_RUN;
      end else begin
         case (st_r)
            CCS_ST_RUN: begin
               if (lor_now && shutdown_enable_i && path_r == CCS_SRC_PLL) begin
                  st_r <= CCS_ST_SHUT;
               end
            end
            CCS_ST_SHUT: st_r <= CCS_ST_SHUT;
            default:     st_r <= CCS_ST_RUN;
         endcase
      end
   end

   // ----------------------------------------
   // PLL postscaler and clock dividers
   // ----------------------------------------
   ccs_div_if div_2x ();
   ccs_div_if div_3x ();
   ccs_div_if div_adc ();

   assign div_2x.src    = cln_r[2] & ~pll_pwr_dn_r;
   assign div_2x.shift  = ccs_pscl_shift(postscaler_i);
   assign div_3x.src    = cln_r[3] & ~pll_pwr_dn_r;
   assign div_3x.shift  = ccs_pscl_shift(postscaler_i);
   assign div_adc.src   = ref_lvl_r;
   assign div_adc.shift = ADC_SHIFT[2:0];

   ccs_divider u_div_2x  (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .d(div_2x.divider));
   ccs_divider u_div_3x  (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .d(div_3x.divider));
   ccs_divider u_div_adc (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .d(div_adc.divider));

   // ----------------------------------------
   // Glitch-free 2X path switch
   // ----------------------------------------
   ccs_src_e want;
   logic     clk2x_r, clk2x_d_r, clk3x_r, sys_r, new_lvl;
   assign want    = (pll_select_i && !pll_pwr_dn_r && cln_r[4]) ? CCS_SRC_PLL : CCS_SRC_OSC;
   assign new_lvl = (want == CCS_SRC_PLL) ? div_2x.out : ref_lvl_r;

   // Swap only while both old output and new source are low
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         path_r <= CCS_SRC_OSC;
      end else if (want != path_r && !clk2x_r && !new_lvl) begin
         path_r <= want;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         clk2x_r <= 1'b0;
         clk3x_r <= 1'b0;
      end else if (st_r == CCS_ST_SHUT) begin
         clk2x_r <= 1'b0;
         clk3x_r <= 1'b0;
      end else if (path_r == CCS_SRC_PLL) begin
         clk2x_r <= div_2x.out;
         clk3x_r <= div_3x.out;
      end else begin
         clk2x_r <= ref_lvl_r;
         clk3x_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         clk2x_d_r <= 1'b0;
         sys_r     <= 1'b0;
      end else begin
         clk2x_d_r <= clk2x_r;
         sys_r     <= sys_r ^ (clk2x_r & ~clk2x_d_r);
      end
   end

   // ----------------------------------------
   // Event flags and interrupt request
   // ----------------------------------------
   logic lock_d_r, lor_d_r, lock_flag_r, lor_flag_r;

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lock_d_r    <= 1'b0;
         lor_d_r     <= 1'b0;
         lock_flag_r <= 1'b0;
         lor_flag_r  <= 1'b0;
      end else begin
         lock_d_r <= cln_r[4];
         lor_d_r  <= lor_now;
         // Set beats a simultaneous clear
         if (cln_r[4] && !lock_d_r) begin
            lock_flag_r <= 1'b1;
         end else if (lock_flag_clr_i) begin
            lock_flag_r <= 1'b0;
         end
         if (lor_now && !lor_d_r) begin
            lor_flag_r <= 1'b1;
         end else if (lor_flag_clr_i) begin
            lor_flag_r <= 1'b0;
         end
      end
   end

   assign irq_o = (lock_flag_r & lock_irq_en_i) | (lor_flag_r & lor_irq_en_i);

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign osc_pwr_dn_o     = osc_pwr_dn_r;
   assign osc_stby_o       = osc_stby_r;
   assign pll_pwr_dn_o     = pll_pwr_dn_r;
   assign clk_2x_o         = clk2x_r;
   assign clk_3x_o         = clk3x_r;
   assign sys_clk_o        = sys_r;
   assign osc_clk_o        = ref_lvl_r;
   assign adc_clk_o        = div_adc.out;
   assign hsp_clk_o        = clk2x_r;
   assign pll_src_active_o = (path_r == CCS_SRC_PLL);
   assign ext_ref_active_o = ref_sel_r;
   assign lock_flag_o      = lock_flag_r;
   assign lor_flag_o       = lor_flag_r;
   assign shutdown_o       = (st_r == CCS_ST_SHUT);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   chk_ref_ext_req: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(ref_sel_r) |-> $past(external_reference_select_i)) else $error("External ref taken unasked");
   chk_osc_path: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ($past(path_r) == CCS_SRC_OSC && $past(st_r) == CCS_ST_RUN) |-> clk2x_r == $past(ref_lvl_r))
      else $error("2X does not follow reference");
   chk_pll_path: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ($past(path_r) == CCS_SRC_PLL && $past(st_r) == CCS_ST_RUN) |-> clk2x_r == $past(div_2x.out))
      else $error("2X does not follow postscaler");
   chk_pscl_sat: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (postscaler_i > 3'h5) |-> div_2x.shift == 3'h5) else $error("Postscaler not saturated");
   chk_sys_half: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(clk2x_r) |=> sys_r != $past(sys_r)) else $error("System clock missed a 2X edge");
   chk_lor_shut: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (lor_now && shutdown_enable_i && path_r == CCS_SRC_PLL) |=> shutdown_o ##1 !clk2x_r && pll_pwr_dn_r)
      else $error("Shutdown did not follow reference loss");
   chk_osc_power: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      osc_power_down_i |=> osc_pwr_dn_o && !osc_stby_o) else $error("Oscillator power-down wrong");
   chk_pll_power: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      pll_power_down_i |=> pll_pwr_dn_o && !div_2x.src) else $error("PLL power-down ignored");
   chk_lock_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (cln_r[4] && !lock_d_r) |=> lock_flag_r) else $error("Lock event lost");
   chk_no_runt: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (path_r != $past(path_r)) |-> !$past(clk2x_r) && !$past(new_lvl)) else $error("Path switched while 2X high");
   chk_3x_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ($past(path_r) == CCS_SRC_OSC) |-> !clk3x_r) else $error("3X runs without PLL");
endmodule // ccs_top

// *** sim/ccs_clk_model.sv ***
// Behavioural oscillator, external source and PLL feeding the clock unit
`timescale 1ns/1ps
module ccs_clk_model #(
   parameter real OSC_HALF_NS = 120.0,
   parameter real EXT_HALF_NS = 70.0
) (
   input  wire logic osc_pwr_dn_i,
   input  wire logic pll_pwr_dn_i,
   input  wire logic stop_i,
   output logic      osc_clk_o,
   output logic      ext_clk_o,
   output logic      pll_clk_o,
   output logic      pll_3x_clk_o,
   output logic      pll_lock_o
);
   logic pll_run;

   // A lost reference leaves the loop coasting, still locked, until it is powered down
   assign pll_run = !osc_pwr_dn_i && !pll_pwr_dn_i;

   initial begin
      osc_clk_o    = 1'b0;
      ext_clk_o    = 1'b0;
      pll_clk_o    = 1'b0;
      pll_3x_clk_o = 1'b0;
   end

   // Stopped clocks stand at their last level, as a dead source would
   always #(OSC_HALF_NS) if (!osc_pwr_dn_i && !stop_i) osc_clk_o = ~osc_clk_o;
   always #(EXT_HALF_NS) if (!stop_i) ext_clk_o = ~ext_clk_o;
   always #(OSC_HALF_NS / 8.0) if (pll_run) pll_clk_o = ~pll_clk_o;
   always #(OSC_HALF_NS / 12.0) if (pll_run) pll_3x_clk_o = ~pll_3x_clk_o;

   // Lock only if the loop is still running 200 ns after it started
   always begin
      pll_lock_o = 1'b0;
      wait (pll_run);
      #200;
      if (pll_run) pll_lock_o = 1'b1;
      wait (!pll_run);
   end
endmodule // ccs_clk_model

// *** sim/ccs_top_bench.sv ***
// Self-checking bench of the clock synthesis unit
`timescale 1ns/1ps
module ccs_top_bench;
   import ccs_pkg::*;
   localparam int ADC_SH = 2;
   localparam int I2X = 9, I3X = 8, ISYS = 7, IOSC = 6, IADC = 5, IHSP = 4, MOSC = 3, MEXT = 2, MPLL = 1, M3X = 0;
   logic      ref_clk_i, rst_i, ext_sel, pll_sel, osc_pd, osc_sb, pll_pd, sd_en, lk_en, lr_en, lk_clr, lr_clr, stop;
   ccs_pscl_t pscl;
   logic      m_osc, m_ext, m_pll, m_3x, m_lock;
   logic      osc_pwr_dn_o, osc_stby_o, pll_pwr_dn_o, clk_2x_o, clk_3x_o, sys_clk_o, osc_clk_o, adc_clk_o;
   logic      hsp_clk_o, pll_src_active_o, ext_ref_active_o, lock_flag_o, lor_flag_o, shutdown_o, irq_o;
   int        num_errors = 0, checked = 0, cyc = 0;
   int        cnt[10];

   ccs_top #(.ADC_SHIFT(ADC_SH)) ccs_top_i (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .osc_clk_i(m_osc), .external_clock_input_i(m_ext),
      .pll_clk_i(m_pll), .pll_3x_clk_i(m_3x), .pll_lock_i(m_lock), .external_reference_select_i(ext_sel),
      .pll_select_i(pll_sel), .postscaler_i(pscl), .osc_power_down_i(osc_pd), .osc_standby_i(osc_sb),
      .pll_power_down_i(pll_pd), .shutdown_enable_i(sd_en), .lock_irq_en_i(lk_en), .lor_irq_en_i(lr_en),
      .lock_flag_clr_i(lk_clr), .lor_flag_clr_i(lr_clr), .osc_pwr_dn_o(osc_pwr_dn_o), .osc_stby_o(osc_stby_o),
      .pll_pwr_dn_o(pll_pwr_dn_o), .clk_2x_o(clk_2x_o), .clk_3x_o(clk_3x_o), .sys_clk_o(sys_clk_o),
      .osc_clk_o(osc_clk_o), .adc_clk_o(adc_clk_o), .hsp_clk_o(hsp_clk_o), .pll_src_active_o(pll_src_active_o),
      .ext_ref_active_o(ext_ref_active_o), .lock_flag_o(lock_flag_o), .lor_flag_o(lor_flag_o),
      .shutdown_o(shutdown_o), .irq_o(irq_o));

   ccs_clk_model ccs_clk_model_i (
      .osc_pwr_dn_i(osc_pwr_dn_o), .pll_pwr_dn_i(pll_pwr_dn_o), .stop_i(stop), .osc_clk_o(m_osc),
      .ext_clk_o(m_ext), .pll_clk_o(m_pll), .pll_3x_clk_o(m_3x), .pll_lock_o(m_lock));

   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   // -----------------------------------------
   // Helpers
   // -----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   task automatic cmp_bit(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   // Sampled clocks may land up to tol edges either way
   task automatic cmp_near(input int got, input int exp, input int tol, input string what);
      checked++;
      if (got < exp - tol || got > exp + tol) begin
         num_errors++;
         $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
      end
   endtask

   task automatic measure(input int n);
      logic [9:0] p, c;
      foreach (cnt[k]) cnt[k] = 0;
      p = '1;
      repeat (n) begin
         @(posedge ref_clk_i);
         #1;
         c = {clk_2x_o, clk_3x_o, sys_clk_o, osc_clk_o, adc_clk_o, hsp_clk_o, m_osc, m_ext, m_pll, m_3x};
         for (int k = 0; k < 10; k++) if (c[k] && !p[k]) cnt[k]++;
         p = c;
      end
   endtask

   task automatic do_reset();
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      tick(3);
      rst_i <= 1'b0;
      tick(2);
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // -----------------------------------------
   // Scenarios
   // -----------------------------------------
   task automatic t_reset();
      cmp_bit(ext_ref_active_o, 1'b0, "ext ref after reset");
      cmp_bit(pll_src_active_o, 1'b0, "pll path after reset");
      cmp_bit(shutdown_o, 1'b0, "shutdown after reset");
      $display("t_reset done");
   endtask

   task automatic t_osc();
      measure(2000);
      cmp_near(cnt[I2X], cnt[MOSC], 1, "2x on osc path");
      cmp_near(cnt[IOSC], cnt[MOSC], 1, "osc clock");
      cmp_near(cnt[IHSP], cnt[I2X], 0, "hsp clock");
      cmp_near(cnt[ISYS], cnt[I2X] / 2, 1, "sys clock");
      cmp_near(cnt[IADC], cnt[MOSC] >> ADC_SH, 1, "adc clock");
      cmp_near(cnt[I3X], 0, 0, "3x off osc path");
      $display("t_osc done");
   endtask

   task automatic t_power();
      osc_sb <= 1'b1;
      tick(3);
      cmp_bit(osc_stby_o, 1'b1, "standby");
      osc_pd <= 1'b1;
      pll_pd <= 1'b1;
      tick(3);
      cmp_bit(osc_pwr_dn_o, 1'b1, "osc power down");
      cmp_bit(osc_stby_o, 1'b0, "standby under power down");
      cmp_bit(pll_pwr_dn_o, 1'b1, "pll power down");
      osc_pd <= 1'b0;
      osc_sb <= 1'b0;
      tick(300);
      cmp_bit(pll_pwr_dn_o, 1'b1, "pll still down");
      cmp_bit(lor_flag_o, 1'b0, "no loss while powered down");
      pll_pd <= 1'b0;
      tick(3);
      cmp_bit(pll_pwr_dn_o, 1'b0, "pll powered");
      $display("t_power done");
   endtask

   task automatic t_ext();
      ext_sel <= 1'b1;
      for (int i = 0; i < 400 && ext_ref_active_o !== 1'b1; i++) tick(1);
      cmp_bit(ext_ref_active_o, 1'b1, "ext ref taken");
      measure(2000);
      cmp_near(cnt[I2X], cnt[MEXT], 1, "2x on ext ref");
      ext_sel <= 1'b0;
      for (int i = 0; i < 400 && ext_ref_active_o !== 1'b0; i++) tick(1);
      cmp_bit(ext_ref_active_o, 1'b0, "internal ref back");
      $display("t_ext done");
   endtask

   task automatic t_pll();
      int s;
      for (int i = 0; i < 400 && lock_flag_o !== 1'b1; i++) tick(1);
      lk_en <= 1'b1;
      tick(2);
      cmp_bit(irq_o, 1'b1, "lock irq");
      lk_clr <= 1'b1;
      tick(1);
      lk_clr <= 1'b0;
      tick(3);
      cmp_bit(lock_flag_o, 1'b0, "lock flag cleared");
      cmp_bit(irq_o, 1'b0, "irq cleared");
      pll_sel <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         pscl <= c[2:0];
         tick(300);
         cmp_bit(pll_src_active_o, 1'b1, "pll path taken");
         s = (c > 5) ? 5 : c;
         measure(2400);
         cmp_near(cnt[I2X], cnt[MPLL] >> s, 1, "2x postscaled");
         cmp_near(cnt[I3X], cnt[M3X] >> s, 2, "3x postscaled");
         if (c == 0) cmp_near(cnt[ISYS], cnt[MOSC] * 4, 2, "sys at top rate");
      end
      $display("t_pll done");
   endtask

   task automatic t_loss();
      sd_en <= 1'b1;
      lr_en <= 1'b1;
      pscl  <= 3'h0;
      tick(2);
      cmp_bit(lor_flag_o, 1'b0, "no loss while running");
      stop <= 1'b1;
      for (int i = 0; i < 400 && lor_flag_o !== 1'b1; i++) tick(1);
      cmp_bit(lor_flag_o, 1'b1, "loss flag");
      cmp_bit(irq_o, 1'b1, "loss irq");
      tick(3);
      cmp_bit(shutdown_o, 1'b1, "shutdown");
      cmp_bit(pll_pwr_dn_o, 1'b1, "pll off in shutdown");
      stop <= 1'b0;
      measure(200);
      cmp_near(cnt[I2X] + cnt[I3X], 0, 0, "clocks held low");
      cmp_bit(shutdown_o, 1'b1, "shutdown sticks");
      lr_clr <= 1'b1;
      tick(1);
      lr_clr <= 1'b0;
      tick(2);
      cmp_bit(lor_flag_o, 1'b0, "loss flag cleared");
      cmp_bit(irq_o, 1'b0, "loss irq cleared");
      pll_sel <= 1'b0;
      sd_en   <= 1'b0;
      do_reset();
      cmp_bit(shutdown_o, 1'b0, "shutdown cleared by reset");
      $display("t_loss done");
   endtask

   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         num_errors++;
         $display("Error at %0t: run did not finish", $time);
         summarize();
      end
   end

   initial begin
      rst_i = 1'b1;
      {ext_sel, pll_sel, osc_pd, osc_sb, pll_pd, sd_en, lk_en, lr_en, lk_clr, lr_clr, stop} = '0;
      pscl = 3'h0;
      do_reset();
      t_reset();
      t_osc();
      t_power();
      t_ext();
      t_pll();
      t_loss();
      summarize();
   end
endmodule // ccs_top_bench
